// >>> design/ocpm_defines.svh
// Register offsets, field positions, reset values and the oscillator frequency table.
// Included by the package, the oscillator divider, the power manager and the bench; holds definitions only.
`ifndef OCPM_DEFINES_SVH
`define OCPM_DEFINES_SVH
`define OCPM_ADDR_W 8
`define OCPM_ADDR_CTRL 8'h00
`define OCPM_ADDR_STBY 8'h04
`define OCPM_ADDR_CLKEN 8'h08
`define OCPM_ADDR_BANKOFF 8'h0c
`define OCPM_ADDR_GUARD 8'h10
`define OCPM_ADDR_GUARDSB 8'h14
`define OCPM_ADDR_STATUS 8'h18
`define OCPM_CTRL_W 7
`define OCPM_CTRL_ROUTE 0
`define OCPM_CTRL_DIV_LSB 1
`define OCPM_CTRL_DIV_W 4
`define OCPM_CTRL_OSC_OFF 5
`define OCPM_CTRL_PLL_OFF 6
`define OCPM_CTRL_RST 7'h00
`define OCPM_STBY_W 4
`define OCPM_STBY_BG 0
`define OCPM_STBY_POR 1
`define OCPM_STBY_OSC 2
`define OCPM_STBY_PLL 3
`define OCPM_STBY_RST 4'h0
`define OCPM_CLKEN_RST 1'b1
`define OCPM_BANKOFF_RST 1'b0
`define OCPM_GUARD_RST 1'b0
`define OCPM_ST_DROP 10
`define OCPM_SEL_W 5
`define OCPM_FREQ_COUNT 5'h15
`define OCPM_FREQ_DEFAULT 5'h00
`define OCPM_FREQ_ENTRY_W 18
`define OCPM_FREQ_TABLE_W 378
`define OCPM_CLK_KHZ 18'h30d40
`define OCPM_FREQ_KHZ_TABLE { \
  18'h20788, 18'h15a5e, 18'h103c4, 18'h0cfd0, 18'h0ad2a, 18'h09470, 18'h081e2, \
  18'h07378, 18'h067e8, 18'h04fec, 18'h039bc, 18'h033f4, 18'h027f6, 18'h023d2, \
  18'h02076, 18'h01b58, 18'h015a4, 18'h010c2, 18'h00c62, 18'h0099c, 18'h00820}
`endif

// >>> design/ocpm_pkg.sv
// Shared types: standby sequencer states and the oscillator half-period table.
// Expects the defines header on the include path.
`include "ocpm_defines.svh"
package ocpm_pkg;
  typedef enum logic [1:0] {
    OCPM_RUN = 2'b00,
    OCPM_DRAIN = 2'b01,
    OCPM_STBY = 2'b10
  } ocpm_state_type;
  typedef logic [7:0] ocpm_half_lut_type [`OCPM_FREQ_COUNT];
endpackage : ocpm_pkg

// >>> design/ocpm_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes inputs are slow levels; pulses shorter than one clock may be missed.
`timescale 1ns/1ps
module ocpm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage1;

  if (W < 1) begin : g_bad_width
    $error("ocpm_sync: width must be at least one");
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      dout <= '0;
    end else if (ce) begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : ocpm_sync

// >>> design/ocpm_osc_divider.sv
// Oscillator model: master clock from clk by a per-frequency half-period count.
// Assumes freqSel is always a valid table index; the top loads the default for out-of-range choices.
`timescale 1ns/1ps
`include "ocpm_defines.svh"
module ocpm_osc_divider #(
  parameter int DIVW = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire logic [`OCPM_SEL_W-1:0] freqSel,
  input wire logic [DIVW-1:0] divSel,
  output logic oscClk,
  output logic [`OCPM_SEL_W-1:0] curSel
);
  localparam int LW = 8 + DIVW + 1;

  function automatic ocpm_pkg::ocpm_half_lut_type build_lut();
    ocpm_pkg::ocpm_half_lut_type lut;
    logic [`OCPM_FREQ_TABLE_W-1:0] tab;
    int f;
    int h;
    tab = `OCPM_FREQ_KHZ_TABLE;
    for (int i = 0; i < `OCPM_FREQ_COUNT; i++) begin
      f = int'(tab[i*`OCPM_FREQ_ENTRY_W +: `OCPM_FREQ_ENTRY_W]);
      h = (int'(`OCPM_CLK_KHZ) + f) / (2 * f);
      lut[i] = 8'((h < 1) ? 1 : h);
    end
    return lut;
  endfunction : build_lut

  // Rounded to whole clk cycles; the fastest settings only approximate
  localparam ocpm_pkg::ocpm_half_lut_type HALF_LUT = build_lut();

  logic [LW-1:0] cnt;
  logic [LW-1:0] curLen;
  logic [LW-1:0] nextLen;

  if (DIVW < 1 || DIVW > 8) begin : g_bad_div
    $error("ocpm_osc_divider: divider width must lie in 1..8");
  end

  always_comb begin
    nextLen = LW'(HALF_LUT[freqSel]) * (LW'(divSel) + LW'(1));
  end

  // New length only taken at the end of a low phase, so no runt pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      oscClk <= 1'b0;
      curLen <= LW'(HALF_LUT[`OCPM_FREQ_DEFAULT]);
      curSel <= `OCPM_FREQ_DEFAULT;
    end else if (ce) begin
      if (cnt != '0) begin
        cnt <= cnt - LW'(1);
      end else if (oscClk) begin
        oscClk <= 1'b0;
        cnt <= curLen - LW'(1);
      end else if (run) begin
        curLen <= nextLen;
        curSel <= freqSel;
        oscClk <= 1'b1;
        cnt <= nextLen - LW'(1);
      end
    end
  end
endmodule : ocpm_osc_divider

// >>> design/ocpm_power_manager.sv
// Oscillator control, standby power sequencing, clock and buffer gating.
// Assumes config strobes and serial-core standby/wake are on clk; pins are async.
`timescale 1ns/1ps
`include "ocpm_defines.svh"
module ocpm_power_manager #(
  parameter int NETS = 8,
  parameter int BANKS = 4,
  parameter int INBUFS = 16,
  parameter int DIVW = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic cfgClkBitsValid,
  input wire logic cfgFreqGiven,
  input wire logic [`OCPM_SEL_W-1:0] cfgFreqSel,
  input wire logic cfgOscEnable,
  input wire logic cfgWakeEnable,
  input wire logic cfgLowVoltPart,
  input wire logic userOscEnable,
  input wire logic supplyDropMain,
  input wire logic supplyDropLow,
  input wire logic pllClksLow,
  input wire logic sbStandby,
  input wire logic sbWake,
  input wire logic [`OCPM_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic treeClk,
  output logic pllRefClk,
  output logic oscPowered,
  output logic pllPowerDown,
  output logic bandgapOff,
  output logic porMonitorOff,
  output logic reconfigReq,
  output logic standbyActive,
  output logic [NETS-1:0] netEnable,
  output logic [BANKS-1:0] bankBufOff,
  output logic [INBUFS-1:0] inBufOff
);
  logic [3:0] syncOut;
  logic userOscS;
  logic dropMainS;
  logic dropLowS;
  logic pllLowS;
  logic [`OCPM_CTRL_W-1:0] ctrlReg;
  logic [`OCPM_STBY_W-1:0] stbyReg;
  logic [BANKS-1:0] bankOffReg;
  logic [INBUFS-1:0] guardReg;
  logic [INBUFS-1:0] guardSbReg;
  logic [`OCPM_SEL_W-1:0] freqSel;
  logic [`OCPM_SEL_W-1:0] curSel;
  logic oscClk;
  logic dropSeen;
  logic stbyReq;
  logic wakeReq;
  logic bgEff;
  logic bgCut;
  logic pllOffReq;
  logic oscRunReq;
  logic dropNow;
  logic inStby;
  logic [31:0] statusWord;
  ocpm_pkg::ocpm_state_type state;
  ocpm_pkg::ocpm_state_type next_state;

  if (NETS < 1 || NETS > 32 || BANKS < 1 || BANKS > 32 || INBUFS < 1 || INBUFS > 32)
  begin : g_bad_size
    $error("ocpm_power_manager: net, bank and buffer counts must lie in 1..32");
  end
  if (DIVW < 1 || DIVW > `OCPM_CTRL_DIV_W) begin : g_bad_div
    $error("ocpm_power_manager: divider width does not fit the control field");
  end

  // Pins and the PLL status come from other domains
  ocpm_sync #(
    .W(4)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .din({userOscEnable, supplyDropMain, supplyDropLow, pllClksLow}),
    .dout(syncOut)
  );

  assign userOscS = syncOut[3];
  assign dropMainS = syncOut[2];
  assign dropLowS = syncOut[1];
  assign pllLowS = syncOut[0];

  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrlReg <= `OCPM_CTRL_RST;
      stbyReg <= `OCPM_STBY_RST;
      netEnable <= {NETS{`OCPM_CLKEN_RST}};
      bankOffReg <= {BANKS{`OCPM_BANKOFF_RST}};
      guardReg <= {INBUFS{`OCPM_GUARD_RST}};
      guardSbReg <= {INBUFS{`OCPM_GUARD_RST}};
    end else if (ce && regWrite) begin
      case (regAddr)
        `OCPM_ADDR_CTRL: begin
          ctrlReg <= regWdata[`OCPM_CTRL_W-1:0];
        end
        `OCPM_ADDR_STBY: begin
          stbyReg <= regWdata[`OCPM_STBY_W-1:0];
        end
        `OCPM_ADDR_CLKEN: begin
          netEnable <= regWdata[NETS-1:0];
        end
        `OCPM_ADDR_BANKOFF: begin
          bankOffReg <= regWdata[BANKS-1:0];
        end
        `OCPM_ADDR_GUARD: begin
          guardReg <= regWdata[INBUFS-1:0];
        end
        `OCPM_ADDR_GUARDSB: begin
          guardSbReg <= regWdata[INBUFS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads; data valid only in the cycle after the strobe
  always_comb begin
    statusWord = 32'({dropSeen, porMonitorOff, bandgapOff, pllPowerDown,
                      standbyActive, oscPowered, curSel});
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (ce) begin
      if (regRead) begin
        case (regAddr)
          `OCPM_ADDR_CTRL: regRdata <= 32'(ctrlReg);
          `OCPM_ADDR_STBY: regRdata <= 32'(stbyReg);
          `OCPM_ADDR_CLKEN: regRdata <= 32'(netEnable);
          `OCPM_ADDR_BANKOFF: regRdata <= 32'(bankOffReg);
          `OCPM_ADDR_GUARD: regRdata <= 32'(guardReg);
          `OCPM_ADDR_GUARDSB: regRdata <= 32'(guardSbReg);
          `OCPM_ADDR_STATUS: regRdata <= statusWord;
          default: regRdata <= '0;
        endcase
      end else begin
        regRdata <= '0;
      end
    end
  end

  // Master clock frequency selection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      freqSel <= `OCPM_FREQ_DEFAULT;
    end else if (ce && cfgClkBitsValid) begin
      if (cfgFreqGiven && cfgFreqSel < `OCPM_FREQ_COUNT) begin
        freqSel <= cfgFreqSel;
      end else begin
        freqSel <= `OCPM_FREQ_DEFAULT;
      end
    end
  end

  a_default_freq: assert property (@(posedge clk) disable iff (!resetn)
    (ce && cfgClkBitsValid && !cfgFreqGiven) |=> (freqSel == `OCPM_FREQ_DEFAULT))
    else $error("Missing frequency choice did not restore the default");

  a_freq_load: assert property (@(posedge clk) disable iff (!resetn)
    (ce && cfgClkBitsValid && cfgFreqGiven && cfgFreqSel < `OCPM_FREQ_COUNT)
    |=> (freqSel == $past(cfgFreqSel)))
    else $error("Configured frequency not taken on the clock bits");

  // Standby sequencer
  assign stbyReq = cfgWakeEnable & sbStandby;
  assign wakeReq = cfgWakeEnable & sbWake;
  assign inStby = (state == ocpm_pkg::OCPM_STBY);
  assign bgEff = stbyReg[`OCPM_STBY_BG] & cfgLowVoltPart;

  always_comb begin
    next_state = state;
    case (state)
      ocpm_pkg::OCPM_RUN: begin
        if (stbyReq) begin
          if (stbyReg[`OCPM_STBY_PLL] || bgEff) begin
            next_state = ocpm_pkg::OCPM_DRAIN;
          end else begin
            next_state = ocpm_pkg::OCPM_STBY;
          end
        end
      end
      ocpm_pkg::OCPM_DRAIN: begin
        if (wakeReq) begin
          next_state = ocpm_pkg::OCPM_RUN;
        end else if (pllLowS) begin
          next_state = ocpm_pkg::OCPM_STBY;
        end
      end
      ocpm_pkg::OCPM_STBY: begin
        if (wakeReq) begin
          next_state = ocpm_pkg::OCPM_RUN;
        end
      end
      default: begin
        next_state = ocpm_pkg::OCPM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ocpm_pkg::OCPM_RUN;
      standbyActive <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      standbyActive <= (next_state == ocpm_pkg::OCPM_STBY);
    end
  end

  a_wake_gated: assert property (@(posedge clk) disable iff (!resetn)
    (state == ocpm_pkg::OCPM_RUN && !cfgWakeEnable) |=> (state == ocpm_pkg::OCPM_RUN))
    else $error("Standby entered without wake-up enable");

  // Bandgap waits for the PLL so its clocks are low before power goes
  assign bgCut = inStby & bgEff & pllPowerDown;
  assign pllOffReq = ctrlReg[`OCPM_CTRL_PLL_OFF] |
                     ((state != ocpm_pkg::OCPM_RUN) & (stbyReg[`OCPM_STBY_PLL] | bgEff));
  assign oscRunReq = cfgOscEnable & userOscS & ~ctrlReg[`OCPM_CTRL_OSC_OFF] &
                     ~(inStby & stbyReg[`OCPM_STBY_OSC]) & ~bgCut;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pllPowerDown <= 1'b0;
    end else if (ce) begin
      pllPowerDown <= pllOffReq & (pllPowerDown | pllLowS);
    end
  end

  a_pll_low_first: assert property (@(posedge clk) disable iff (!resetn)
    $rose(pllPowerDown) |-> $past(pllLowS))
    else $error("PLL powered off before its output clocks were low");

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscPowered <= 1'b0;
      bandgapOff <= 1'b0;
      porMonitorOff <= 1'b0;
      bankBufOff <= '0;
      inBufOff <= '0;
    end else if (ce) begin
      oscPowered <= oscRunReq;
      bandgapOff <= bgCut;
      porMonitorOff <= (inStby & stbyReg[`OCPM_STBY_POR]) | bgCut;
      bankBufOff <= bankOffReg | {BANKS{bgCut}};
      inBufOff <= guardReg | (guardSbReg & {INBUFS{inStby}});
    end
  end

  a_osc_user_off: assert property (@(posedge clk) disable iff (!resetn)
    (ce && !(userOscS && cfgOscEnable)) |=> !oscPowered)
    else $error("Oscillator powered while disabled");

  a_stby_osc_off: assert property (@(posedge clk) disable iff (!resetn)
    (ce && inStby && stbyReg[`OCPM_STBY_OSC]) |=> !oscPowered)
    else $error("Oscillator still powered in standby");

  a_guard_gate: assert property (@(posedge clk) disable iff (!resetn)
    ce |=> ((inBufOff & $past(guardReg)) == $past(guardReg)))
    else $error("Guarded input buffer left on");

  a_bg_low_volt: assert property (@(posedge clk) disable iff (!resetn)
    bandgapOff |-> cfgLowVoltPart)
    else $error("Bandgap shut down on a part that is not low voltage");

  a_bg_analog_off: assert property (@(posedge clk) disable iff (!resetn)
    bandgapOff |-> (porMonitorOff && pllPowerDown && !oscPowered && (&bankBufOff)))
    else $error("Analog circuits still on while bandgap is off");

  // The precise detector only while the monitor runs; the coarse one always
  assign dropNow = (dropMainS & ~porMonitorOff) | dropLowS;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reconfigReq <= 1'b0;
      dropSeen <= 1'b0;
    end else if (ce) begin
      reconfigReq <= dropNow;
      dropSeen <= dropNow | (dropSeen & ~(regWrite && regAddr == `OCPM_ADDR_STATUS &&
                                          regWdata[`OCPM_ST_DROP]));
    end
  end

  a_drop_reconfig: assert property (@(posedge clk) disable iff (!resetn)
    (ce && dropLowS) |=> (reconfigReq && dropSeen))
    else $error("Supply drop did not request reconfiguration");

  // Oscillator and its routing
  ocpm_osc_divider #(
    .DIVW(DIVW)
  ) u_osc (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(oscPowered),
    .freqSel(freqSel),
    .divSel(ctrlReg[`OCPM_CTRL_DIV_LSB +: DIVW]),
    .oscClk(oscClk),
    .curSel(curSel)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      treeClk <= 1'b0;
      pllRefClk <= 1'b0;
    end else if (ce) begin
      treeClk <= oscClk & ~ctrlReg[`OCPM_CTRL_ROUTE];
      pllRefClk <= oscClk & ctrlReg[`OCPM_CTRL_ROUTE];
    end
  end

  a_route_excl: assert property (@(posedge clk) disable iff (!resetn)
    !(treeClk && pllRefClk))
    else $error("Oscillator routed to tree and PLL at once");

  a_route_tree: assert property (@(posedge clk) disable iff (!resetn)
    (ce && !ctrlReg[`OCPM_CTRL_ROUTE]) |=> (treeClk == $past(oscClk)))
    else $error("Oscillator clock not passed to the clock tree");
endmodule : ocpm_power_manager

// >>> test/ocpm_pll_model.sv
// PLL stand-in: output clocks settle low a fixed lag after a stop request.
// Assumes stopClk comes from the bench on clk; LAG stands for the PLL drain time.
`timescale 1ns/1ps
module ocpm_pll_model #(
  parameter int LAG = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic stopClk,
  output logic pllClksLow
);
  int cnt;
  // Restart drops the flag at once, so it never claims low while clocks run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      pllClksLow <= 1'b0;
    end else if (!stopClk) begin
      cnt <= 0;
      pllClksLow <= 1'b0;
    end else if (cnt < LAG) begin
      cnt <= cnt + 1;
    end else begin
      pllClksLow <= 1'b1;
    end
  end
endmodule : ocpm_pll_model

// >>> test/ocpm_power_manager_tb_top.sv
// Self-checking bench: registers, oscillator control, clock routing, standby sequencing.
// Assumes the design files, the defines header and the PLL stand-in are compiled first.
`timescale 1ns/1ps
`include "ocpm_defines.svh"
module ocpm_power_manager_tb_top;
  logic clk, resetn, ce, cfgClkBitsValid, cfgFreqGiven, cfgOscEnable, cfgWakeEnable;
  logic cfgLowVoltPart, userOscEnable, supplyDropMain, supplyDropLow, pllClksLow;
  logic sbStandby, sbWake, regWrite, regRead, rdLast, stopClk;
  logic [4:0] cfgFreqSel;
  logic [7:0] regAddr, netEnable;
  logic [31:0] regWdata, regRdata, wClk, wBank, wGuard, wGuardSb;
  logic treeClk, pllRefClk, oscPowered, pllPowerDown, bandgapOff, porMonitorOff;
  logic reconfigReq, standbyActive;
  logic [3:0] bankBufOff;
  logic [15:0] inBufOff;
  logic [31:0] expQ[$];
  int n_errors = 0;
  int num_checks = 0;
  int per;

  ocpm_power_manager #(.NETS(8), .BANKS(4), .INBUFS(16), .DIVW(4)) uut (
    .clk(clk), .resetn(resetn), .ce(ce), .cfgClkBitsValid(cfgClkBitsValid),
    .cfgFreqGiven(cfgFreqGiven), .cfgFreqSel(cfgFreqSel), .cfgOscEnable(cfgOscEnable),
    .cfgWakeEnable(cfgWakeEnable), .cfgLowVoltPart(cfgLowVoltPart),
    .userOscEnable(userOscEnable), .supplyDropMain(supplyDropMain),
    .supplyDropLow(supplyDropLow), .pllClksLow(pllClksLow), .sbStandby(sbStandby),
    .sbWake(sbWake), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .treeClk(treeClk), .pllRefClk(pllRefClk),
    .oscPowered(oscPowered), .pllPowerDown(pllPowerDown), .bandgapOff(bandgapOff),
    .porMonitorOff(porMonitorOff), .reconfigReq(reconfigReq),
    .standbyActive(standbyActive), .netEnable(netEnable), .bankBufOff(bankBufOff),
    .inBufOff(inBufOff));
  ocpm_pll_model #(.LAG(20)) pll (.clk(clk), .resetn(resetn), .stopClk(stopClk),
    .pllClksLow(pllClksLow));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic hang();
    n_errors++;
    $display("Error at %0t ns: wait bound used up, got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  endtask : hang

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Read results are compared by the monitor below, one cycle after the strobe
  always @(posedge clk) begin
    if (rdLast === 1'b1 && expQ.size() > 0) chk(regRdata, expQ.pop_front());
    rdLast <= regRead;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd

  // Long settle so the oscillator can finish its slowest low phase
  task automatic cfg(input logic [4:0] sel, input logic given);
    @(posedge clk);
    cfgFreqSel <= sel;
    cfgFreqGiven <= given;
    cfgClkBitsValid <= 1'b1;
    @(posedge clk);
    cfgClkBitsValid <= 1'b0;
    cyc(120);
  endtask : cfg

  task automatic period(input logic usePll, output int p);
    int edges;
    logic prev, cur;
    edges = 0;
    prev = 1'b1;
    p = 0;
    for (int n = 0; n < 2000 && edges < 2; n++) begin
      @(posedge clk);
      #1;
      cur = usePll ? pllRefClk : treeClk;
      if (prev === 1'b0 && cur === 1'b1) edges++;
      if (edges == 1) p++;
      prev = cur;
    end
    if (edges < 2) hang();
  endtask : period

  task automatic wait_pd();
    int k;
    for (k = 0; k < 100 && pllPowerDown !== 1'b1; k++) @(posedge clk);
    if (k == 100) hang();
  endtask : wait_pd

  task automatic sby(input logic lowV);
    cfgLowVoltPart <= lowV;
    wr(`OCPM_ADDR_STBY, 32'h0000000f);
    sbStandby <= 1'b1;
    stopClk <= 1'b1;
    @(posedge clk);
    sbStandby <= 1'b0;
    cyc(10);
    chk(32'(pllPowerDown), 32'h0);
    wait_pd();
    cyc(3);
    chk(32'(standbyActive), 32'h1);
    chk(32'(oscPowered), 32'h0);
    chk(32'(bandgapOff), 32'(lowV));
    chk(32'(porMonitorOff), 32'h1);
    chk(32'(bankBufOff), lowV ? 32'hf : wBank & 32'hf);
    chk(32'(inBufOff), (wGuard | wGuardSb) & 32'hffff);
    supplyDropMain <= 1'b1;
    cyc(5);
    chk(32'(reconfigReq), 32'h0);
    supplyDropLow <= 1'b1;
    cyc(5);
    chk(32'(reconfigReq), 32'h1);
    supplyDropMain <= 1'b0;
    supplyDropLow <= 1'b0;
    sbWake <= 1'b1;
    stopClk <= 1'b0;
    @(posedge clk);
    sbWake <= 1'b0;
    cyc(6);
    chk({standbyActive, pllPowerDown, oscPowered}, 32'h1);
  endtask : sby

  initial begin
    {resetn, cfgClkBitsValid, cfgFreqGiven, cfgOscEnable, cfgWakeEnable} = '0;
    {cfgLowVoltPart, userOscEnable, supplyDropMain, supplyDropLow} = '0;
    {sbStandby, sbWake, regWrite, regRead, rdLast, stopClk} = '0;
    {cfgFreqSel, regAddr, regWdata} = '0;
    ce = 1'b1;
    void'($urandom(32'h0185cdc7));
    cyc(10);
    resetn <= 1'b1;
    cyc(2);
    chk(32'(netEnable), 32'hff);
    chk({bandgapOff, porMonitorOff, pllPowerDown, oscPowered, standbyActive}, 0);
    rd(`OCPM_ADDR_STATUS, 32'h0);
    rd(8'h1c, 32'h0);
    cfgOscEnable <= 1'b1;
    userOscEnable <= 1'b1;
    cyc(5);
    chk(32'(oscPowered), 32'h1);
    userOscEnable <= 1'b0;
    cyc(5);
    chk(32'(oscPowered), 32'h0);
    userOscEnable <= 1'b1;
    cfgOscEnable <= 1'b0;
    cyc(5);
    chk(32'(oscPowered), 32'h0);
    cfgOscEnable <= 1'b1;
    wr(`OCPM_ADDR_CTRL, 32'h20);
    cyc(4);
    chk(32'(oscPowered), 32'h0);
    wr(`OCPM_ADDR_CTRL, 32'h0);
    cyc(4);
    chk(32'(oscPowered), 32'h1);
    for (int i = 0; i < 23; i++) begin
      cfg(5'(i), 1'b1);
      rd(`OCPM_ADDR_STATUS, 32'h20 | (i < 21 ? i : 0));
    end
    cfg(5'd9, 1'b1);
    cfg(5'($urandom_range(20)), 1'b0);
    rd(`OCPM_ADDR_STATUS, 32'h20);
    period(1'b0, per);
    chk(per, 96);
    wr(`OCPM_ADDR_CTRL, 32'h3);
    period(1'b1, per);
    chk(per, 192);
    chk(32'(treeClk), 32'h0);
    cfg(5'd20, 1'b1);
    period(1'b1, per);
    chk(per, 4);
    period(1'b1, per);
    chk(per, 4);
    wGuardSb = $urandom;
    wClk = $urandom;
    wBank = $urandom;
    wGuard = $urandom;
    wr(`OCPM_ADDR_CTRL, 32'h0);
    wr(`OCPM_ADDR_CLKEN, wClk);
    wr(`OCPM_ADDR_BANKOFF, wBank);
    wr(`OCPM_ADDR_GUARD, wGuard);
    wr(`OCPM_ADDR_GUARDSB, wGuardSb);
    cyc(2);
    chk(32'(netEnable), wClk & 32'hff);
    chk(32'(bankBufOff), wBank & 32'hf);
    chk(32'(inBufOff), wGuard & 32'hffff);
    rd(`OCPM_ADDR_CLKEN, wClk & 32'hff);
    rd(`OCPM_ADDR_BANKOFF, wBank & 32'hf);
    rd(`OCPM_ADDR_GUARDSB, wGuardSb & 32'hffff);
    period(1'b0, per);
    chk(per, 2);
    wr(`OCPM_ADDR_CTRL, 32'h40);
    cyc(10);
    chk(32'(pllPowerDown), 32'h0);
    stopClk <= 1'b1;
    wait_pd();
    chk(32'(pllClksLow), 32'h1);
    wr(`OCPM_ADDR_CTRL, 32'h0);
    stopClk <= 1'b0;
    supplyDropMain <= 1'b1;
    cyc(5);
    chk({pllPowerDown, reconfigReq}, 32'h1);
    supplyDropMain <= 1'b0;
    cyc(5);
    rd(`OCPM_ADDR_STATUS, 32'h434);
    wr(`OCPM_ADDR_STATUS, 32'h400);
    rd(`OCPM_ADDR_STATUS, 32'h34);
    sbStandby <= 1'b1;
    @(posedge clk);
    sbStandby <= 1'b0;
    cyc(40);
    chk(32'(standbyActive), 32'h0);
    cfgWakeEnable <= 1'b1;
    sby(1'b1);
    sby(1'b0);
    rd(`OCPM_ADDR_STBY, 32'hf);
    rd(`OCPM_ADDR_GUARD, wGuard & 32'hffff);
    rd(`OCPM_ADDR_CTRL, 32'h0);
    // Oscillator-only standby takes the direct path, no PLL drain
    wr(`OCPM_ADDR_STBY, 32'h4);
    sbStandby <= 1'b1;
    @(posedge clk);
    sbStandby <= 1'b0;
    cyc(3);
    chk({standbyActive, pllPowerDown, porMonitorOff, oscPowered}, 32'h8);
    sbWake <= 1'b1;
    @(posedge clk);
    sbWake <= 1'b0;
    cyc(4);
    chk({standbyActive, oscPowered}, 32'h1);
    // Clock enable low must freeze the synchronisers too
    ce <= 1'b0;
    supplyDropLow <= 1'b1;
    cyc(5);
    chk(32'(reconfigReq), 32'h0);
    ce <= 1'b1;
    cyc(5);
    chk(32'(reconfigReq), 32'h1);
    supplyDropLow <= 1'b0;
    cyc(3);
    chk(expQ.size(), 32'h0);
    tally_and_finish();
  end
endmodule : ocpm_power_manager_tb_top
